// file: verilog/i2csg_pkg.sv
package i2csg_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CCRL = 8'h0B;
  localparam logic [7:0] ADDR_CCRH = 8'h0C;
  localparam logic [7:0] ADDR_TRISER = 8'h0D;
  localparam logic [7:0] ADDR_STATUS = 8'h0E;

  // Reset values and writable masks
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CCRL_RST = 8'h00;
  localparam logic [7:0] CCRH_RST = 8'h00;
  localparam logic [7:0] TRISER_RST = 8'h02;
  localparam logic [7:0] CTRL_MASK = 8'h01;
  localparam logic [7:0] CCRH_MASK = 8'hCF;
  localparam logic [7:0] TRISER_MASK = 8'h3F;

  // Field positions
  localparam int EN_BIT = 0;
  localparam int FS_BIT = 7;
  localparam int DUTY_BIT = 6;
  localparam int CCRH_HI_MSB = 3;
  localparam int MAX_RISE_TIME_FIELD_MSB = 5;
  localparam int CCR_W = 12;
  localparam int MAX_RISE_TIME_FIELD_W = 6;
  localparam int LEN_W = 17;
  localparam int UNIT_W = 5;

  localparam logic [LEN_W-1:0] LEN_ONE = 17'h00001;

  // Phase lengths in units of the clock control value
  localparam logic [UNIT_W-1:0] UNITS_STD_HIGH = 5'h01;
  localparam logic [UNIT_W-1:0] UNITS_STD_LOW = 5'h01;
  localparam logic [UNIT_W-1:0] UNITS_F2_HIGH = 5'h01;
  localparam logic [UNIT_W-1:0] UNITS_F2_LOW = 5'h02;
  localparam logic [UNIT_W-1:0] UNITS_F169_HIGH = 5'h09;
  localparam logic [UNIT_W-1:0] UNITS_F169_LOW = 5'h10;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_RISE, ST_HIGH} i2csg_state_t;

  typedef struct packed {
    logic fast;
    logic duty;
    logic [CCR_W-1:0] clock_control_value;
    logic [MAX_RISE_TIME_FIELD_W-1:0] max_rise_time_field;
  } i2csg_cfg_t;

  // Length of one SCL phase in master clock cycles, never below one
  function automatic logic [LEN_W-1:0] i2csg_phase_len(input i2csg_cfg_t cfg, input logic low);
    logic [UNIT_W-1:0] units;
    logic [LEN_W-1:0] len;
    if (!cfg.fast) begin
      units = low ? UNITS_STD_LOW : UNITS_STD_HIGH;
    end else if (!cfg.duty) begin
      units = low ? UNITS_F2_LOW : UNITS_F2_HIGH;
    end else begin
      units = low ? UNITS_F169_LOW : UNITS_F169_HIGH;
    end
    len = LEN_W'(cfg.clock_control_value) * LEN_W'(units);
    if (len == '0) begin
      len = LEN_ONE;
    end
    return len;
  endfunction : i2csg_phase_len

endpackage : i2csg_pkg

// file: verilog/i2csg_link_sense.sv
`timescale 1ns/1ps
module i2csg_link_sense (
  input wire logic link_clk,
  input wire logic arst_n,
  input wire logic scl_pin,
  output logic scl_level
);

  logic meta_q;

  // Two stages on the link clock before the level leaves this domain
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b1;
      scl_level <= 1'b1;
    end else begin
      meta_q <= scl_pin;
      scl_level <= meta_q;
    end
  end

  a_link_sync_delay: assert property (@(posedge link_clk) disable iff (!arst_n)
    ##2 (scl_level == $past(scl_pin, 2)))
    else $error("link level does not follow the pin two edges later");

endmodule : i2csg_link_sense

// file: verilog/i2csg_scl_gen.sv
`timescale 1ns/1ps
// Summary of operation
// - Bit 7 selects standard or fast timing
// - Bit 6 picks fast ratio 2 or 16/9
// - High nibble of value; standard high=low=value
// - Fast, duty clear: high one unit, low two
// - Fast, duty set: high nine, low sixteen units
// - Rise time field bounds SCL feedback wait
// - Reset: high register zero, rise register two
// - Low eight value bits in separate register
module i2csg_scl_gen (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic LINK_CLK,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RD_DATA,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE
);

  logic [7:0] ctrl_q;
  logic [7:0] ccrl_q;
  logic [7:0] ccrh_q;
  logic [7:0] triser_q;
  logic en_q;
  i2csg_pkg::i2csg_cfg_t cfg_q;
  i2csg_pkg::i2csg_state_t state_q;
  logic [i2csg_pkg::LEN_W-1:0] cnt_q;
  logic [i2csg_pkg::MAX_RISE_TIME_FIELD_W-1:0] rise_cnt_q;
  logic scl_link;
  logic scl_meta_q;
  logic scl_hi_q;
  logic scl_oe_q;
  logic [7:0] rd_data_q;
  logic [i2csg_pkg::LEN_W-1:0] low_len;
  logic [i2csg_pkg::LEN_W-1:0] high_len;
  logic rise_done;
  logic wr_ctrl;
  logic wr_ccrl;
  logic wr_ccrh;
  logic wr_triser;

  assign wr_ctrl = WR_EN && (ADDR == i2csg_pkg::ADDR_CTRL);
  assign wr_ccrl = WR_EN && (ADDR == i2csg_pkg::ADDR_CCRL);
  assign wr_ccrh = WR_EN && (ADDR == i2csg_pkg::ADDR_CCRH);
  assign wr_triser = WR_EN && (ADDR == i2csg_pkg::ADDR_TRISER);

  // Pin is sampled on the link clock, then carried over as a level
  i2csg_link_sense u_link_sense (
    .link_clk(LINK_CLK),
    .arst_n(ARST_N),
    .scl_pin(SCL_I),
    .scl_level(scl_link)
  );

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_meta_q <= 1'b1;
      scl_hi_q <= 1'b1;
    end else if (CE) begin
      scl_meta_q <= scl_link;
      scl_hi_q <= scl_meta_q;
    end
  end

  // Register file
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= i2csg_pkg::CTRL_RST;
      ccrl_q <= i2csg_pkg::CCRL_RST;
      ccrh_q <= i2csg_pkg::CCRH_RST;
      triser_q <= i2csg_pkg::TRISER_RST;
    end else if (CE) begin
      if (wr_ctrl) begin
        ctrl_q <= WR_DATA & i2csg_pkg::CTRL_MASK;
      end
      if (wr_ccrl) begin
        ccrl_q <= WR_DATA;
      end
      if (wr_ccrh) begin
        ccrh_q <= WR_DATA & i2csg_pkg::CCRH_MASK;
      end
      if (wr_triser) begin
        triser_q <= WR_DATA & i2csg_pkg::TRISER_MASK;
      end
    end
  end

  assign en_q = ctrl_q[i2csg_pkg::EN_BIT];

  // Working copy follows the registers only while disabled, so a late write cannot tear a running period
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      // Rise field starts at its register's reset value so the two agree out of reset
      cfg_q <= '{fast: 1'b0, duty: 1'b0, clock_control_value: '0, max_rise_time_field: i2csg_pkg::TRISER_RST[i2csg_pkg::MAX_RISE_TIME_FIELD_W-1:0]};
    end else if (CE && !en_q) begin
      cfg_q.fast <= ccrh_q[i2csg_pkg::FS_BIT];
      cfg_q.duty <= ccrh_q[i2csg_pkg::DUTY_BIT];
      cfg_q.clock_control_value <= {ccrh_q[i2csg_pkg::CCRH_HI_MSB:0], ccrl_q};
      cfg_q.max_rise_time_field <= triser_q[i2csg_pkg::MAX_RISE_TIME_FIELD_MSB:0];
    end
  end

  assign low_len = i2csg_pkg::i2csg_phase_len(cfg_q, 1'b1);
  assign high_len = i2csg_pkg::i2csg_phase_len(cfg_q, 1'b0);

  // Rise wait ends after max_rise_time_field cycles even if the line never reads high
  assign rise_done = (7'({1'b0, rise_cnt_q}) + 7'h01) >= 7'({1'b0, cfg_q.max_rise_time_field});

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rise_cnt_q <= '0;
    end else if (CE) begin
      if (state_q != i2csg_pkg::ST_RISE) begin
        rise_cnt_q <= '0;
      end else if (rise_cnt_q != '1) begin
        rise_cnt_q <= rise_cnt_q + 6'h01;
      end
    end
  end

  // Phase sequencer
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= i2csg_pkg::ST_IDLE;
      cnt_q <= '0;
      scl_oe_q <= 1'b0;
    end else if (CE) begin
      if (!en_q) begin
        state_q <= i2csg_pkg::ST_IDLE;
        cnt_q <= '0;
        scl_oe_q <= 1'b0;
      end else begin
        case (state_q)
          i2csg_pkg::ST_IDLE: begin
            state_q <= i2csg_pkg::ST_LOW;
            cnt_q <= low_len - i2csg_pkg::LEN_ONE;
            scl_oe_q <= 1'b1;
          end
          i2csg_pkg::ST_LOW: begin
            if (cnt_q == '0) begin
              state_q <= i2csg_pkg::ST_RISE;
              scl_oe_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q - i2csg_pkg::LEN_ONE;
            end
          end
          i2csg_pkg::ST_RISE: begin
            if (scl_hi_q || rise_done) begin
              state_q <= i2csg_pkg::ST_HIGH;
              cnt_q <= high_len - i2csg_pkg::LEN_ONE;
            end
          end
          i2csg_pkg::ST_HIGH: begin
            if (cnt_q == '0) begin
              state_q <= i2csg_pkg::ST_LOW;
              cnt_q <= low_len - i2csg_pkg::LEN_ONE;
              scl_oe_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q - i2csg_pkg::LEN_ONE;
            end
          end
          default: begin
            state_q <= i2csg_pkg::ST_IDLE;
            scl_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Read port; data stand only in the cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_data_q <= 8'h00;
    end else if (CE) begin
      if (RD_EN) begin
        case (ADDR)
          i2csg_pkg::ADDR_CTRL: rd_data_q <= ctrl_q;
          i2csg_pkg::ADDR_CCRL: rd_data_q <= ccrl_q;
          i2csg_pkg::ADDR_CCRH: rd_data_q <= ccrh_q;
          i2csg_pkg::ADDR_TRISER: rd_data_q <= triser_q;
          i2csg_pkg::ADDR_STATUS: rd_data_q <= {5'h00, scl_oe_q, scl_hi_q, en_q};
          default: rd_data_q <= 8'h00;
        endcase
      end else begin
        rd_data_q <= 8'h00;
      end
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      SCL_O <= 1'b0;
    end else if (CE) begin
      SCL_O <= 1'b0;
    end
  end

  assign SCL_OE = scl_oe_q;
  assign RD_DATA = rd_data_q;

  // Checks

  logic first_q;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb_sys @(posedge CLK_SYS);
  endclocking

  default disable iff (!ARST_N);

  sequence s_cfg_load;
    CE && !en_q;
  endsequence

  sequence s_rise_seen;
    CE && en_q && (state_q == i2csg_pkg::ST_RISE) && scl_hi_q;
  endsequence

  sequence s_rise_timeout;
    CE && en_q && (state_q == i2csg_pkg::ST_RISE) && !scl_hi_q && rise_done;
  endsequence

  sequence s_low_start;
    CE && en_q && (state_q == i2csg_pkg::ST_HIGH) && (cnt_q == '0);
  endsequence

  sequence s_low_run;
    CE && en_q && (state_q == i2csg_pkg::ST_LOW) && (cnt_q != '0);
  endsequence

  sequence s_low_end;
    CE && en_q && (state_q == i2csg_pkg::ST_LOW) && (cnt_q == '0);
  endsequence

  a_fs_select: assert property (
    s_cfg_load |=> (cfg_q.fast == $past(ccrh_q[7])))
    else $error("speed mode not taken from bit 7");

  a_duty_select: assert property (
    s_cfg_load |=> (cfg_q.duty == $past(ccrh_q[6])))
    else $error("duty select not taken from bit 6");

  a_std_lengths: assert property (
    (!cfg_q.fast && cfg_q.clock_control_value != '0) |->
      (high_len == 17'(cfg_q.clock_control_value)) && (low_len == 17'(cfg_q.clock_control_value)))
    else $error("standard phases differ from the control value");

  a_fast_ratio_two: assert property (
    (cfg_q.fast && !cfg_q.duty && cfg_q.clock_control_value != '0) |->
      (high_len == 17'(cfg_q.clock_control_value)) && (low_len == 17'(cfg_q.clock_control_value) * 17'h00002))
    else $error("fast ratio two phases wrong");

  a_fast_ratio_169: assert property (
    (cfg_q.fast && cfg_q.duty && cfg_q.clock_control_value != '0) |->
      (high_len == 17'(cfg_q.clock_control_value) * 17'h00009) && (low_len == 17'(cfg_q.clock_control_value) * 17'h00010))
    else $error("fast ratio 16/9 phases wrong");

  a_rise_bound: assert property (
    (CE && state_q == i2csg_pkg::ST_RISE) |-> (rise_cnt_q <= cfg_q.max_rise_time_field))
    else $error("rise wait ran past the programmed bound");

  a_reset_values: assert property (
    first_q |-> (ccrh_q == 8'h00) && (triser_q == 8'h02))
    else $error("reset values of clock control high or rise time wrong");

  a_low_reg_write: assert property (
    (CE && wr_ccrl) |=> (ccrl_q == $past(WR_DATA)) && (cfg_q.clock_control_value[7:0] == $past(cfg_q.clock_control_value[7:0]) || !$past(en_q)))
    else $error("low control register write lost");

  a_high_on_sense: assert property (
    s_rise_seen |=> (state_q == i2csg_pkg::ST_HIGH) && (cnt_q == high_len - 17'h00001))
    else $error("high phase not started when line sensed high");

  a_high_on_timeout: assert property (
    s_rise_timeout |=> (state_q == i2csg_pkg::ST_HIGH) && !scl_oe_q)
    else $error("high phase not started at rise timeout");

  a_low_drive: assert property (
    s_low_start |=> scl_oe_q && (state_q == i2csg_pkg::ST_LOW) && (cnt_q == low_len - 17'h00001))
    else $error("low phase not driven after high count");

  a_oe_tracks_low: assert property (
    scl_oe_q == (state_q == i2csg_pkg::ST_LOW))
    else $error("pull-down enable out of step with low phase");

  a_disable_release: assert property (
    (CE && !en_q) |=> !scl_oe_q && (state_q == i2csg_pkg::ST_IDLE))
    else $error("line still driven after disable");

  a_rd_one_cycle: assert property (
    (CE && !RD_EN) |=> (rd_data_q == 8'h00))
    else $error("read data stand outside the answer cycle");

  a_ccr_load: assert property (
    s_cfg_load |=> (cfg_q.clock_control_value[11:8] == $past(ccrh_q[3:0])) && (cfg_q.clock_control_value[7:0] == $past(ccrl_q)))
    else $error("clock control value not assembled from both registers");

  a_max_rise_time_field_load: assert property (
    s_cfg_load |=> (cfg_q.max_rise_time_field == $past(triser_q[5:0])))
    else $error("rise field not taken into the working copy");

  a_low_count: assert property (
    s_low_run |=> scl_oe_q && (state_q == i2csg_pkg::ST_LOW) && (cnt_q == $past(cnt_q) - 17'h00001))
    else $error("low phase count did not step down");

  a_rise_enter: assert property (
    s_low_end |=> !scl_oe_q && (state_q == i2csg_pkg::ST_RISE) && (rise_cnt_q == '0))
    else $error("rise wait not entered after low count");

  a_cfg_frozen: assert property (
    (CE && en_q) |=> $stable(cfg_q))
    else $error("working copy changed while enabled");

  // Pausing must hold every count, or a phase would come out short
  a_ce_freeze: assert property (
    !CE |=> $stable(state_q) && $stable(cnt_q) && $stable(ctrl_q) && $stable(ccrl_q) && $stable(rd_data_q))
    else $error("state moved while clock enable low");

  a_sync_stage: assert property (
    CE |=> (scl_hi_q == $past(scl_meta_q)))
    else $error("second sync stage skipped");

endmodule : i2csg_scl_gen

// file: bench/i2csg_bus_model.sv
`timescale 1ns/1ps
module i2csg_bus_model (
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic [15:0] stretch_ns,
  output logic scl_line
);
  logic hold;
  // Pull-up wins unless the master or a stretching device pulls low
  assign scl_line = (scl_oe ? scl_o : 1'b1) & ~hold;
  initial hold = 1'b0;
  // A slow device keeps SCL low after release, for the bench-set span
  always @(negedge scl_oe) begin
    if (stretch_ns != 16'h0000) begin
      hold = 1'b1;
      #(stretch_ns);
      hold = 1'b0;
    end
  end
endmodule : i2csg_bus_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic scl_o;
  logic scl_oe;
  logic scl_line;
  logic [15:0] stretch_ns = 16'h0000;
  logic ce = 1'b1;
  int errors = 0;
  int checks_done = 0;

  // 100 MHz, a multiple of 10 MHz as fast mode wants
  always #5 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #40 link_clk = ~link_clk;
  end

  i2csg_scl_gen i_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .CE(ce), .LINK_CLK(link_clk),
    .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
    .SCL_I(scl_line), .SCL_O(scl_o), .SCL_OE(scl_oe));
  i2csg_bus_model i_bus (.scl_o(scl_o), .scl_oe(scl_oe), .stretch_ns(stretch_ns), .scl_line(scl_line));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
  endtask : rd

  // Config only while disabled; rise field is max rise plus one, integer part
  task automatic setup(input logic fs, input logic dt, input logic [11:0] v, input logic [5:0] tr);
    wr(i2csg_pkg::ADDR_CTRL, 8'h00);
    wr(i2csg_pkg::ADDR_CCRL, v[7:0]);
    wr(i2csg_pkg::ADDR_CCRH, {fs, dt, 2'b00, v[11:8]});
    wr(i2csg_pkg::ADDR_TRISER, {2'b00, tr});
    wr(i2csg_pkg::ADDR_CTRL, 8'h01);
  endtask : setup

  // Lengths of the first low phase and of the following released span
  task automatic measure(output int lo, output int hi);
    int n;
    lo = 0;
    hi = 0;
    n = 0;
    while (scl_oe !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    while (scl_oe === 1'b1 && lo < 4000) begin
      @(negedge clk_sys);
      lo++;
    end
    while (scl_oe === 1'b0 && hi < 4000) begin
      @(negedge clk_sys);
      hi++;
    end
  endtask : measure

  task automatic t_regs();
    logic [7:0] d;
    rd(i2csg_pkg::ADDR_CCRH, d);
    check("ccrh_rst", d, 8'h00);
    rd(i2csg_pkg::ADDR_TRISER, d);
    check("triser_rst", d, 8'h02);
    rd(i2csg_pkg::ADDR_CCRL, d);
    check("ccrl_rst", d, 8'h00);
    rd(8'h05, d);
    check("unmapped", d, 8'h00);
    wr(i2csg_pkg::ADDR_CCRH, 8'hFF);
    rd(i2csg_pkg::ADDR_CCRH, d);
    check("ccrh_rw", d, 8'hCF);
    wr(i2csg_pkg::ADDR_TRISER, 8'hFF);
    rd(i2csg_pkg::ADDR_TRISER, d);
    check("triser_rw", d, 8'h3F);
    wr(i2csg_pkg::ADDR_CCRL, 8'hA5);
    rd(i2csg_pkg::ADDR_CCRL, d);
    check("ccrl_rw", d, 8'hA5);
  endtask : t_regs

  // Mode table: low length exact, released span bounded by the rise field when stretched
  task automatic t_modes();
    logic fs[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic dt[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int v[4] = '{4, 4, 1, 260};
    int tr[4] = '{5, 5, 5, 63};
    int st[4] = '{0, 2000, 2000, 0};
    int ul[4] = '{1, 2, 16, 1};
    int uh[4] = '{1, 1, 9, 1};
    int lo;
    int hi;
    int hmax;
    for (int i = 0; i < 4; i++) begin
      stretch_ns <= 16'(st[i]);
      setup(fs[i], dt[i], 12'(v[i]), 6'(tr[i]));
      measure(lo, hi);
      check("low_len", 32'(lo), 32'(ul[i] * v[i]));
      hmax = (st[i] != 0) ? uh[i] * v[i] + tr[i] + 1 : uh[i] * v[i] + 25;
      check("high_min", 32'(hi >= uh[i] * v[i]), 32'h1);
      check("high_max", 32'(hi <= hmax), 32'h1);
    end
  endtask : t_modes

  // A value written while enabled must not reach the running generator
  task automatic t_gating();
    int lo;
    int hi;
    logic [7:0] d;
    stretch_ns <= 16'h0000;
    setup(1'b0, 1'b0, 12'h004, 6'h05);
    wr(i2csg_pkg::ADDR_CCRL, 8'h08);
    measure(lo, hi);
    measure(lo, hi);
    check("gated_low", 32'(lo), 32'h4);
    wr(i2csg_pkg::ADDR_CTRL, 8'h00);
    repeat (2) @(negedge clk_sys);
    check("released", 32'(scl_oe), 32'h0);
    check("scl_drive", 32'(scl_o), 32'h0);
    rd(i2csg_pkg::ADDR_STATUS, d);
    check("status_off", 32'(d & 8'hFD), 32'h0);
  endtask : t_gating

  // Clock enable low must hold the generator and the registers
  task automatic t_freeze();
    logic [7:0] d;
    logic oe_seen;
    int n;
    stretch_ns <= 16'h0000;
    setup(1'b0, 1'b0, 12'h004, 6'h05);
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(i2csg_pkg::ADDR_CCRL, 8'h33);
    oe_seen = scl_oe;
    n = 0;
    repeat (20) begin
      @(negedge clk_sys);
      n += int'(scl_oe !== oe_seen);
    end
    check("frozen_oe", 32'(n), 32'h0);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd(i2csg_pkg::ADDR_CCRL, d);
    check("frozen_wr", d, 8'h04);
    rd(i2csg_pkg::ADDR_STATUS, d);
    check("status_on", 32'(d[0]), 32'h1);
  endtask : t_freeze

  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_modes();
    t_gating();
    t_freeze();
    close_out();
  end

  initial begin
    #200000;
    errors++;
    close_out();
  end
endmodule : testbench
